// File: core/ssa_front_end.v
/* Probe-to-logger command front end: command line, SDI-12, USB relay, LED.
   Assumes clk-synchronous byte streams from UART, SDI-12, USB and RS-485. */
// Summary of operation
// - LED steady without probe; 1 Hz, 0.1 Hz sleep
// - sleeping, magnet lights LED one second
// - magnet actuation starts full probe rediscovery
// - power-up also starts probe rediscovery
// - logger traffic on SDI-12 or RS-232, one
// - SDI-12 port acts as v1.3 sensor
// - answer standard SDI-12 commands
// - SDI-12 Z command carries serial subset
// - hash prompt, case-blind command words
// - only spaces split command words
// - carriage return ends and runs command
// - USB relays traffic straight to probe
// - firmware update accepted over USB
// - probe traffic goes over RS-485 link
// - detect probe, fetch its address, id
`timescale 1ns/100ps
`include "ssa_consts.vh"
module ssa_front_end #(
    parameter TICK_CYC = `SSA_TICK_NS / `SSA_CLK_NS
) (
    input wire clk,
    input wire rstn,
    input wire probe_present,
    input wire sleep_mode,
    input wire mag_sw,
    input wire sel_sdi,
    input wire rs_rx_valid,
    input wire [7:0] rs_rx_data,
    output reg rs_tx_valid,
    output reg [7:0] rs_tx_data,
    input wire rs_tx_ready,
    input wire sdi_rx_valid,
    input wire [7:0] sdi_rx_data,
    output reg sdi_tx_valid,
    output reg [7:0] sdi_tx_data,
    input wire sdi_tx_ready,
    input wire usb_active,
    input wire usb_fw_req,
    input wire usb_rx_valid,
    input wire [7:0] usb_rx_data,
    output reg usb_rx_ready,
    output reg usb_tx_valid,
    output reg [7:0] usb_tx_data,
    input wire usb_tx_ready,
    output reg p_tx_valid,
    output reg [7:0] p_tx_data,
    input wire p_tx_ready,
    input wire p_rx_valid,
    input wire [7:0] p_rx_data,
    input wire p_rx_last,
    output reg p_rx_ready,
    output reg [7:0] sdi_addr,
    output reg [7:0] sdi_id,
    output reg fw_update,
    output reg led
);
    localparam S_PR0 = 5'b00001;
    localparam S_PR1 = 5'b00010;
    localparam S_IDLE = 5'b00100;
    localparam S_WAIT = 5'b01000;
    localparam S_ERR = 5'b10000;

    reg rst_s1, rst_s2;
    wire tick;
    reg [4:0] st_r;
    reg [47:0] word_r;
    reg [2:0] wlen_r;
    reg wdone_r;
    reg [1:0] sdi_pos_r;
    reg [7:0] sdi_let_r;
    reg disc_pend_r, disc_act_r, disc_byte_r;
    reg [7:0] cmd_pend_r;
    reg mag_d_r;
    reg [7:0] led_cnt_r, mag_cnt_r;
    reg [7:0] lc;
    wire [7:0] in_ch = sel_sdi ? sdi_rx_data : rs_rx_data;
    wire in_v = sel_sdi ? sdi_rx_valid : rs_rx_valid;
    wire log_busy = rs_tx_valid | sdi_tx_valid;
    wire mag_rise = mag_sw & ~mag_d_r;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    ssa_tick #(.PERIOD(TICK_CYC)) u_tick (
        .clk(clk),
        .rst_n(rst_s2),
        .tick(tick)
    );

    // case folding: 'A'..'Z' become lower case
    always @* begin
        lc = in_ch;
        if (in_ch >= `SSA_CH_UP_A && in_ch <= `SSA_CH_UP_Z)
            lc = in_ch + `SSA_CH_CASE;
    end

    function [7:0] dec_word;
        input [47:0] w;
        input sdi_ext;
        begin
            dec_word = `SSA_C_NONE;
            if (w == `SSA_W_SER)
                dec_word = `SSA_C_SER;
            else if (w == `SSA_W_VER)
                dec_word = `SSA_C_VER;
            else if (w == `SSA_W_SSN)
                dec_word = `SSA_C_SSN;
            else if (w == `SSA_W_PARA)
                dec_word = `SSA_C_PARA;
            else if (w == `SSA_W_WIPE)
                dec_word = `SSA_C_WIPE;
            else if (w == `SSA_W_DATA && !sdi_ext)
                dec_word = `SSA_C_DATA;
        end
    endfunction

    // logger side: line parser, SDI-12 parser and transmit path
    always @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            st_r <= S_PR0;
            word_r <= 48'h0000_0000_0000;
            wlen_r <= 3'd0;
            wdone_r <= 1'b0;
            sdi_pos_r <= 2'd0;
            sdi_let_r <= 8'h00;
            cmd_pend_r <= `SSA_C_NONE;
            rs_tx_valid <= 1'b0;
            rs_tx_data <= 8'h00;
            sdi_tx_valid <= 1'b0;
            sdi_tx_data <= 8'h00;
            p_rx_ready <= 1'b0;
            sdi_addr <= `SSA_ADDR_RST;
            sdi_id <= `SSA_ID_RST;
        end else begin
            if (rs_tx_valid && rs_tx_ready)
                rs_tx_valid <= 1'b0;
            if (sdi_tx_valid && sdi_tx_ready)
                sdi_tx_valid <= 1'b0;
            p_rx_ready <= ~log_busy & ~p_rx_ready & ~usb_active & ~disc_act_r;
            // probe answers relayed to whichever logger port is in use
            if (p_rx_valid && p_rx_ready) begin
                p_rx_ready <= 1'b0;
                rs_tx_data <= p_rx_data;
                sdi_tx_data <= p_rx_data;
                rs_tx_valid <= ~sel_sdi;
                sdi_tx_valid <= sel_sdi;
                if (p_rx_last && st_r == S_WAIT)
                    st_r <= S_PR0;
            end
            // discovery answer: address byte then id byte
            if (disc_act_r && p_rx_valid) begin
                if (!disc_byte_r)
                    sdi_addr <= p_rx_data;
                else
                    sdi_id <= p_rx_data;
            end
            case (st_r)
                S_PR0: begin
                    if (!log_busy && !sel_sdi && !p_rx_ready) begin
                        rs_tx_data <= `SSA_CH_HASH;
                        rs_tx_valid <= 1'b1;
                        st_r <= S_PR1;
                    end else if (sel_sdi) begin
                        st_r <= S_IDLE;
                    end
                end
                S_PR1: begin
                    if (!rs_tx_valid) begin
                        rs_tx_data <= `SSA_CH_SPACE;
                        rs_tx_valid <= 1'b1;
                        st_r <= S_IDLE;
                    end
                end
                S_ERR: begin
                    if (!log_busy) begin
                        rs_tx_data <= `SSA_CH_QMARK;
                        rs_tx_valid <= 1'b1;
                        st_r <= S_PR0;
                    end
                end
                S_WAIT: begin
                    if (sel_sdi && cmd_pend_r == `SSA_C_NONE)
                        st_r <= S_IDLE;
                end
                S_IDLE: begin
                    if (in_v && !sel_sdi) begin
                        if (in_ch == `SSA_CH_CR) begin
                            // carriage return runs the line
                            wlen_r <= 3'd0;
                            wdone_r <= 1'b0;
                            word_r <= 48'h0000_0000_0000;
                            if (wlen_r == 3'd7 || dec_word(word_r, 1'b0) == `SSA_C_NONE) begin
                                st_r <= S_ERR;
                            end else begin
                                cmd_pend_r <= dec_word(word_r, 1'b0);
                                st_r <= S_WAIT;
                            end
                        end else if (in_ch == `SSA_CH_SPACE) begin
                            if (wlen_r != 3'd0)
                                wdone_r <= 1'b1;
                        end else if (!wdone_r) begin
                            // tabs and commas stay inside the word
                            if (wlen_r == 3'd6)
                                wlen_r <= 3'd7;
                            else if (wlen_r != 3'd7) begin
                                word_r <= {word_r[39:0], lc};
                                wlen_r <= wlen_r + 3'd1;
                            end
                        end
                    end else if (in_v) begin
                        // SDI-12 frame: address, letter, optional word, '!'
                        if (sdi_pos_r == 2'd0) begin
                            sdi_pos_r <= 2'd1;
                            wdone_r <= (in_ch != sdi_addr) && (in_ch != `SSA_CH_QMARK);
                            sdi_let_r <= in_ch;
                            word_r <= 48'h0000_0000_0000;
                            wlen_r <= 3'd0;
                        end else if (in_ch == `SSA_CH_BANG) begin
                            sdi_pos_r <= 2'd0;
                            if (wdone_r) begin
                                st_r <= S_IDLE;
                            end else if (sdi_pos_r == 2'd1) begin
                                // address query answers the held address
                                sdi_tx_data <= sdi_addr;
                                sdi_tx_valid <= 1'b1;
                            end else if (sdi_let_r == "A") begin
                                sdi_addr <= word_r[7:0];
                                sdi_tx_data <= word_r[7:0];
                                sdi_tx_valid <= 1'b1;
                            end else if (sdi_let_r == "Z") begin
                                if (dec_word(word_r, 1'b1) != `SSA_C_NONE) begin
                                    cmd_pend_r <= dec_word(word_r, 1'b1);
                                    st_r <= S_WAIT;
                                end
                            end else begin
                                // C, D, I, M, V go to the probe by letter
                                cmd_pend_r <= `SSA_C_SDI | {1'b0, sdi_let_r[6:0]};
                                st_r <= S_WAIT;
                            end
                        end else if (sdi_pos_r == 2'd1) begin
                            sdi_let_r <= in_ch;
                            sdi_pos_r <= 2'd2;
                        end else if (wlen_r != 3'd7) begin
                            word_r <= {word_r[39:0], lc};
                            wlen_r <= wlen_r + 3'd1;
                        end
                    end
                end
                default: st_r <= S_PR0;
            endcase
            if (p_tx_valid && p_tx_ready && !disc_act_r && !usb_active)
                cmd_pend_r <= `SSA_C_NONE;
        end
    end

    // probe side: discovery, USB relay and command issue
    always @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            disc_pend_r <= 1'b1; // every power-up rediscovers
            disc_act_r <= 1'b0;
            disc_byte_r <= 1'b0;
            mag_d_r <= 1'b0;
            p_tx_valid <= 1'b0;
            p_tx_data <= 8'h00;
            usb_rx_ready <= 1'b0;
            usb_tx_valid <= 1'b0;
            usb_tx_data <= 8'h00;
            fw_update <= 1'b0;
        end else begin
            mag_d_r <= mag_sw;
            fw_update <= usb_active & usb_fw_req;
            if (mag_rise)
                disc_pend_r <= 1'b1;
            if (p_tx_valid && p_tx_ready)
                p_tx_valid <= 1'b0;
            if (usb_tx_valid && usb_tx_ready)
                usb_tx_valid <= 1'b0;
            usb_rx_ready <= usb_active & ~p_tx_valid & ~usb_rx_ready & ~disc_act_r;
            if (disc_act_r && p_rx_valid) begin
                disc_byte_r <= 1'b1;
                if (p_rx_last) begin
                    disc_act_r <= 1'b0;
                    disc_byte_r <= 1'b0;
                end
            end
            // usb traffic passes both ways untouched
            if (usb_active && p_rx_valid && !usb_tx_valid && !disc_act_r) begin
                usb_tx_data <= p_rx_data;
                usb_tx_valid <= 1'b1;
            end
            if (!p_tx_valid) begin
                if (disc_pend_r && probe_present && !disc_act_r && !mag_rise) begin
                    p_tx_data <= `SSA_C_DISC;
                    p_tx_valid <= 1'b1;
                    disc_pend_r <= 1'b0;
                    disc_act_r <= 1'b1;
                end else if (usb_active && usb_rx_valid && usb_rx_ready) begin
                    usb_rx_ready <= 1'b0;
                    p_tx_data <= usb_rx_data;
                    p_tx_valid <= 1'b1;
                end else if (!usb_active && !disc_act_r && cmd_pend_r != `SSA_C_NONE) begin
                    p_tx_data <= cmd_pend_r;
                    p_tx_valid <= 1'b1;
                end
            end
        end
    end

    // status LED, paced by the tenth-second tick
    always @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            led_cnt_r <= 8'h00;
            mag_cnt_r <= 8'h00;
            led <= 1'b1;
        end else begin
            if (mag_rise && sleep_mode)
                mag_cnt_r <= `SSA_TICKS_MAG_ON;
            else if (tick && mag_cnt_r != 8'h00)
                mag_cnt_r <= mag_cnt_r - 8'h01;
            if (tick) begin
                if (led_cnt_r >= (sleep_mode ? `SSA_TICKS_SLEEP_PER : `SSA_TICKS_1HZ_HALF * 8'h02) - 8'h01)
                    led_cnt_r <= 8'h00;
                else
                    led_cnt_r <= led_cnt_r + 8'h01;
            end
            if (!probe_present)
                led <= 1'b1;
            else if (sleep_mode)
                led <= (mag_cnt_r != 8'h00) || (led_cnt_r < `SSA_TICKS_SLEEP_ON);
            else
                led <= led_cnt_r < `SSA_TICKS_1HZ_HALF;
        end
    end
endmodule

// File: core/ssa_consts.vh
/* Front end constants: characters, command codes, timing.
   Assumes a plain Verilog-2005 includer. */
`ifndef SSA_CONSTS_VH
`define SSA_CONSTS_VH

`define SSA_CLK_NS 32'h0000_0004
`define SSA_TICK_NS 32'h05F5_E100
`define SSA_TICKS_1HZ_HALF 8'h05
`define SSA_TICKS_SLEEP_ON 8'h05
`define SSA_TICKS_SLEEP_PER 8'h64
`define SSA_TICKS_MAG_ON 8'h0A

`define SSA_CH_CR 8'h0D
`define SSA_CH_SPACE 8'h20
`define SSA_CH_HASH 8'h23
`define SSA_CH_QMARK 8'h3F
`define SSA_CH_BANG 8'h21
`define SSA_CH_UP_A 8'h41
`define SSA_CH_UP_Z 8'h5A
`define SSA_CH_CASE 8'h20

`define SSA_W_DATA 48'h0000_6461_7461
`define SSA_W_SER 48'h0000_0000_736E
`define SSA_W_VER 48'h0000_0076_6572
`define SSA_W_SSN 48'h0000_0073_736E
`define SSA_W_PARA 48'h0000_7061_7261
`define SSA_W_WIPE 48'h7477_6970_6562

`define SSA_C_NONE 8'h00
`define SSA_C_DATA 8'h01
`define SSA_C_SER 8'h02
`define SSA_C_VER 8'h03
`define SSA_C_SSN 8'h04
`define SSA_C_PARA 8'h05
`define SSA_C_WIPE 8'h06
`define SSA_C_DISC 8'h0F
`define SSA_C_SDI 8'h80

`define SSA_ADDR_RST 8'h30
`define SSA_ID_RST 8'h00

`endif

// File: core/ssa_tick.v
/* One-cycle enable every PERIOD clocks.
   Assumes an already released active-low reset. */
`timescale 1ns/100ps
module ssa_tick #(
    parameter PERIOD = 32'd25000000
) (
    input wire clk,
    input wire rst_n,
    output reg tick
);
    reg [31:0] cnt_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt_r >= PERIOD - 32'd1) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'd1;
            tick <= 1'b0;
        end
    end
endmodule

// File: bench/ssa_front_end_chk.sv
/* Port assertions for ssa_front_end.
   Assumes TICK_CYC equals that of the bound instance. */
`timescale 1ns/100ps
module ssa_front_end_chk #(
    parameter TICK_CYC = 10
) (
    input wire clk,
    input wire rstn,
    input wire probe_present,
    input wire sel_sdi,
    input wire mag_sw,
    input wire usb_active,
    input wire usb_fw_req,
    input wire fw_update,
    input wire rs_tx_valid,
    input wire [7:0] rs_tx_data,
    input wire rs_tx_ready,
    input wire sdi_tx_valid,
    input wire [7:0] sdi_tx_data,
    input wire sdi_tx_ready,
    input wire p_tx_valid,
    input wire [7:0] p_tx_data,
    input wire p_tx_ready,
    input wire usb_rx_ready,
    input wire led
);
    // led goes high the clock after the probe is lost, not on a tick; still allow two tick periods
    reg [31:0] np_cnt_r;
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            np_cnt_r <= 32'h0000_0000;
        else if (probe_present)
            np_cnt_r <= 32'h0000_0000;
        else if (np_cnt_r < 32'h0001_0000)
            np_cnt_r <= np_cnt_r + 32'h0000_0001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    fw_follow_a: assert property (fw_update == $past(usb_active && usb_fw_req))
        else $error("fw_update late");
    rs_hold_a: assert property (rs_tx_valid && !rs_tx_ready |=> rs_tx_valid && $stable(rs_tx_data))
        else $error("rs char dropped");
    sdi_hold_a: assert property (sdi_tx_valid && !sdi_tx_ready |=> sdi_tx_valid && $stable(sdi_tx_data))
        else $error("sdi char dropped");
    p_hold_a: assert property (p_tx_valid && !p_tx_ready |=> p_tx_valid && $stable(p_tx_data))
        else $error("probe byte dropped");
    led_noprb_a: assert property (np_cnt_r > 2 * TICK_CYC |-> led)
        else $error("led not steady without probe");
    sdi_quiet_a: assert property (!sel_sdi |-> !sdi_tx_valid)
        else $error("sdi port talks in rs mode");
    mag_redisc_a: assert property ($rose(mag_sw) && probe_present && !usb_active
        |-> ##[1:60] p_tx_valid && p_tx_data == 8'h0F) else $error("no rediscovery on magnet");
    usb_gate_a: assert property (!usb_active && !$past(usb_active) |-> !usb_rx_ready)
        else $error("usb taken while not active");
endmodule
bind ssa_front_end ssa_front_end_chk #(.TICK_CYC(TICK_CYC)) ssa_front_end_chk_inst (
    .clk(clk), .rstn(rstn), .probe_present(probe_present), .sel_sdi(sel_sdi),
    .mag_sw(mag_sw), .usb_active(usb_active), .usb_fw_req(usb_fw_req), .fw_update(fw_update),
    .rs_tx_valid(rs_tx_valid), .rs_tx_data(rs_tx_data), .rs_tx_ready(rs_tx_ready),
    .sdi_tx_valid(sdi_tx_valid), .sdi_tx_data(sdi_tx_data), .sdi_tx_ready(sdi_tx_ready),
    .p_tx_valid(p_tx_valid), .p_tx_data(p_tx_data), .p_tx_ready(p_tx_ready),
    .usb_rx_ready(usb_rx_ready), .led(led));

// File: bench/ssa_probe_model.sv
/* Far side: probe on the byte link plus logger and usb readies.
   Assumes the front end holds p_tx until p_tx_ready. */
`timescale 1ns/100ps
module ssa_probe_model (
    input wire clk,
    input wire rstn,
    input wire p_tx_valid,
    input wire [7:0] p_tx_data,
    output wire p_tx_ready,
    output wire p_rx_valid,
    output wire [7:0] p_rx_data,
    output wire p_rx_last,
    input wire p_rx_ready,
    input wire usb_active,
    output wire rs_tx_ready,
    output wire sdi_tx_ready,
    output wire usb_tx_ready
);
    reg [1:0] ph_r;
    reg [1:0] left_r;
    reg disc_r;
    reg [7:0] q0_r;
    reg [7:0] q1_r;
    reg [7:0] last_r;
    // stalls on every ready so held requests get exercised
    assign p_tx_ready = ph_r != 2'h0;
    assign rs_tx_ready = ph_r[0];
    assign sdi_tx_ready = ph_r[1];
    assign usb_tx_ready = ph_r != 2'h3;
    assign p_rx_valid = left_r != 2'h0;
    // released line shows the inverse, never a stale copy
    assign p_rx_data = p_rx_valid ? q0_r : ~last_r;
    assign p_rx_last = left_r == 2'h1;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ph_r <= 2'h0;
            left_r <= 2'h0;
            disc_r <= 1'b0;
            q0_r <= 8'h00;
            q1_r <= 8'h00;
            last_r <= 8'h00;
        end else begin
            ph_r <= ph_r + 2'h1;
            if (p_tx_valid && p_tx_ready) begin
                disc_r <= p_tx_data == 8'h0F;
                q0_r <= p_tx_data == 8'h0F ? 8'h35 : 8'h41;
                q1_r <= p_tx_data == 8'h0F ? 8'h11 : p_tx_data;
                left_r <= 2'h2;
            end else if (p_rx_valid && (disc_r || p_rx_ready || usb_active)) begin
                left_r <= left_r - 2'h1;
                last_r <= q0_r;
                q0_r <= q1_r;
            end
        end
    end
endmodule

// File: bench/ssa_front_end_bench.sv
/* Self-checking bench for ssa_front_end.
   Assumes ssa_probe_model on the far side and a short tick. */
`timescale 1ns/100ps
`include "ssa_consts.vh"
module ssa_front_end_bench;
    localparam TICK = 10;
    logic clk = 1'b0, rstn = 1'b0, probe_present = 1'b1, sleep_mode = 1'b0, mag_sw = 1'b0;
    logic sel_sdi = 1'b0, rs_rx_valid = 1'b0, sdi_rx_valid = 1'b0, usb_rx_valid = 1'b0;
    logic usb_active = 1'b0, usb_fw_req = 1'b0;
    logic [7:0] rs_rx_data = 8'h00, sdi_rx_data = 8'h00, usb_rx_data = 8'h00;
    wire rs_tx_valid, rs_tx_ready, sdi_tx_valid, sdi_tx_ready, usb_rx_ready, usb_tx_valid;
    wire usb_tx_ready, p_tx_valid, p_tx_ready, p_rx_valid, p_rx_last, p_rx_ready, fw_update, led;
    wire [7:0] rs_tx_data, sdi_tx_data, usb_tx_data, p_tx_data, p_rx_data, sdi_addr, sdi_id;
    int num_errors = 0, num_checks = 0, n;
    logic [7:0] rs_q[$], sdi_q[$], usb_q[$], p_q[$];
    always #2 clk = ~clk;
    ssa_front_end #(.TICK_CYC(TICK)) ssa_front_end_inst (.clk(clk), .rstn(rstn),
        .probe_present(probe_present), .sleep_mode(sleep_mode), .mag_sw(mag_sw),
        .sel_sdi(sel_sdi), .rs_rx_valid(rs_rx_valid), .rs_rx_data(rs_rx_data),
        .rs_tx_valid(rs_tx_valid), .rs_tx_data(rs_tx_data), .rs_tx_ready(rs_tx_ready),
        .sdi_rx_valid(sdi_rx_valid), .sdi_rx_data(sdi_rx_data), .sdi_tx_valid(sdi_tx_valid),
        .sdi_tx_data(sdi_tx_data), .sdi_tx_ready(sdi_tx_ready), .usb_active(usb_active),
        .usb_fw_req(usb_fw_req), .usb_rx_valid(usb_rx_valid), .usb_rx_data(usb_rx_data),
        .usb_rx_ready(usb_rx_ready), .usb_tx_valid(usb_tx_valid), .usb_tx_data(usb_tx_data),
        .usb_tx_ready(usb_tx_ready), .p_tx_valid(p_tx_valid), .p_tx_data(p_tx_data),
        .p_tx_ready(p_tx_ready), .p_rx_valid(p_rx_valid), .p_rx_data(p_rx_data),
        .p_rx_last(p_rx_last), .p_rx_ready(p_rx_ready), .sdi_addr(sdi_addr), .sdi_id(sdi_id),
        .fw_update(fw_update), .led(led));
    ssa_probe_model ssa_probe_model_inst (.clk(clk), .rstn(rstn), .p_tx_valid(p_tx_valid),
        .p_tx_data(p_tx_data), .p_tx_ready(p_tx_ready), .p_rx_valid(p_rx_valid),
        .p_rx_data(p_rx_data), .p_rx_last(p_rx_last), .p_rx_ready(p_rx_ready),
        .usb_active(usb_active), .rs_tx_ready(rs_tx_ready), .sdi_tx_ready(sdi_tx_ready),
        .usb_tx_ready(usb_tx_ready));
    always @(posedge clk) begin
        if (rs_tx_valid && rs_tx_ready) rs_q.push_back(rs_tx_data);
        if (sdi_tx_valid && sdi_tx_ready) sdi_q.push_back(sdi_tx_data);
        if (usb_tx_valid && usb_tx_ready) usb_q.push_back(usb_tx_data);
        if (p_tx_valid && p_tx_ready) p_q.push_back(p_tx_data);
    end
    task conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task tmo;
        num_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        conclude;
    endtask
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task chkn(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("unexpected at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic wait_n(ref logic [7:0] q[$], input int k);
        for (int g = 0; g < 600 && q.size() < k; g++) @(posedge clk);
        if (q.size() < k) tmo;
    endtask
    task automatic chk_q(ref logic [7:0] q[$], input logic [31:0] e, input int k);
        chkn(q.size(), k, k);
        for (int i = 0; i < k; i++) chk8(q[i], e[8 * (k - 1 - i) +: 8]);
    endtask
    // rs lines get the carriage return appended, sdi frames do not
    task automatic send(input logic sdi, input string s);
        int i;
        begin
            repeat (20) @(posedge clk);
            for (i = 0; i < s.len() + (sdi ? 0 : 1); i++) begin
                @(posedge clk);
                if (sdi) sdi_rx_valid <= 1'b1;
                else rs_rx_valid <= 1'b1;
                sdi_rx_data <= s[i];
                rs_rx_data <= i == s.len() ? `SSA_CH_CR : s[i];
                @(posedge clk);
                sdi_rx_valid <= 1'b0;
                rs_rx_valid <= 1'b0;
            end
        end
    endtask
    task automatic do_reset(input logic sdi);
        begin
            @(posedge clk);
            rstn <= 1'b0;
            sel_sdi <= sdi;
            repeat (5) @(posedge clk);
            rs_q.delete();
            sdi_q.delete();
            p_q.delete();
            rstn <= 1'b1;
            wait_n(p_q, 1);
            chk8(p_q[0], `SSA_C_DISC);
            repeat (20) @(posedge clk);
            chk8(sdi_addr, 8'h35);
            chk8(sdi_id, 8'h11);
        end
    endtask
    task automatic t_cmd(input string s, input logic [7:0] c);
        begin
            rs_q.delete();
            p_q.delete();
            send(1'b0, s);
            if (c == `SSA_C_NONE) begin
                wait_n(rs_q, 3);
                chk_q(rs_q, 32'h003F_2320, 3);
                chkn(p_q.size(), 0, 0);
            end else begin
                wait_n(rs_q, 4);
                chk8(p_q[0], c);
                chk_q(rs_q, {8'h41, c, 8'h23, 8'h20}, 4);
            end
        end
    endtask
    task automatic run_len(input logic lvl, output int k);
        int g;
        begin
            k = 0;
            for (g = 0; g < 3000 && led !== ~lvl; g++) @(negedge clk);
            for (; g < 3000 && led !== lvl; g++) @(negedge clk);
            for (; g < 3000 && led === lvl; g++) begin
                @(negedge clk);
                k++;
            end
            if (g >= 3000) tmo;
        end
    endtask
    task automatic t_led;
        begin
            run_len(1'b1, n);
            chkn(n, 5 * TICK, 5 * TICK);
            run_len(1'b0, n);
            chkn(n, 5 * TICK, 5 * TICK);
            @(posedge clk) sleep_mode <= 1'b1;
            run_len(1'b1, n);
            run_len(1'b0, n);
            chkn(n, 95 * TICK, 95 * TICK);
            run_len(1'b1, n);
            chkn(n, 5 * TICK, 5 * TICK);
            repeat (20) @(posedge clk);
            p_q.delete();
            mag_sw <= 1'b1;
            run_len(1'b1, n);
            chkn(n, 9 * TICK + 1, 10 * TICK);
            chk8(p_q[0], `SSA_C_DISC);
            @(posedge clk) mag_sw <= 1'b0;
            sleep_mode <= 1'b0;
            probe_present <= 1'b0;
            repeat (3 * TICK) @(negedge clk);
            chk8({7'h00, led}, 8'h01);
            @(posedge clk) probe_present <= 1'b1;
        end
    endtask
    task automatic t_usb;
        int g;
        begin
            p_q.delete();
            usb_q.delete();
            @(posedge clk);
            usb_active <= 1'b1;
            usb_fw_req <= 1'b1;
            usb_rx_valid <= 1'b1;
            usb_rx_data <= 8'h5A;
            g = 0;
            do begin
                @(posedge clk);
                g++;
            end while (usb_rx_ready !== 1'b1 && g < 100);
            usb_rx_valid <= 1'b0;
            if (g >= 100) tmo;
            wait_n(p_q, 1);
            chk8(p_q[0], 8'h5A);
            wait_n(usb_q, 1);
            chk8(usb_q[0], 8'h41);
            chk8({7'h00, fw_update}, 8'h01);
            @(posedge clk) usb_active <= 1'b0;
            usb_fw_req <= 1'b0;
        end
    endtask
    task automatic t_sdi(input string s, input logic [7:0] pb, input logic [7:0] rb);
        begin
            p_q.delete();
            sdi_q.delete();
            send(1'b1, s);
            if (pb != 8'h00) wait_n(p_q, 1);
            if (pb != 8'h00) chk8(p_q[0], pb);
            if (rb != 8'h00) wait_n(sdi_q, 1);
            if (rb != 8'h00) chk8(sdi_q[0], rb);
            repeat (50) @(posedge clk);
            if (pb == 8'h00) chkn(p_q.size(), 0, 0);
        end
    endtask
    initial begin
        do_reset(1'b0);
        wait_n(rs_q, 2);
        chk_q(rs_q, 32'h0000_2320, 2);
        t_cmd("sN", `SSA_C_SER);
        t_cmd("VER", `SSA_C_VER);
        t_cmd("Ssn", `SSA_C_SSN);
        t_cmd("para", `SSA_C_PARA);
        t_cmd("DaTa", `SSA_C_DATA);
        t_cmd("twipeb go", `SSA_C_WIPE);
        t_cmd("da,ta", `SSA_C_NONE);
        t_cmd("sn\t", `SSA_C_NONE);
        t_led;
        t_usb;
        do_reset(1'b1);
        t_sdi("?!", 8'h00, 8'h35);
        t_sdi("5C!", 8'hC3, 8'h41);
        t_sdi("5D!", 8'hC4, 8'h41);
        t_sdi("5I!", 8'hC9, 8'h41);
        t_sdi("5M!", 8'hCD, 8'h41);
        t_sdi("5V!", 8'hD6, 8'h41);
        t_sdi("8M!", 8'h00, 8'h00);
        t_sdi("5A7!", 8'h00, 8'h37);
        chk8(sdi_addr, 8'h37);
        t_sdi("7Zsn!", `SSA_C_SER, 8'h00);
        t_sdi("7Zpara!", `SSA_C_PARA, 8'h00);
        t_sdi("7Ztwipeb!", `SSA_C_WIPE, 8'h00);
        t_sdi("7Zver!", `SSA_C_VER, 8'h00);
        t_sdi("7Zssn!", `SSA_C_SSN, 8'h00);
        conclude;
    end
endmodule
